// ==== sbr_array.sv ====
`default_nettype none

module sbr_array (
  input wire logic pclk,
  input wire logic presetn,
  sbr_mem_if.mem   mif
);
  import sbr_pkg::*;

  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] lane_mask;

  assign mif.old_word = mem[mif.addr];

  // Each lane: 8 data bits plus its parity bit, treated alike
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign mif.new_word[i*LANE_DATA_W +: LANE_DATA_W] = mif.we[i] ?
        mif.wword[i*LANE_DATA_W +: LANE_DATA_W] : mif.old_word[i*LANE_DATA_W +: LANE_DATA_W];
    assign mif.new_word[DATA_W+i] = mif.we[i] ? mif.wword[DATA_W+i] : mif.old_word[DATA_W+i];
    assign lane_mask[i*LANE_DATA_W +: LANE_DATA_W] = {LANE_DATA_W{mif.we[i]}};
    assign lane_mask[DATA_W+i] = mif.we[i];
  end

  always_ff @(posedge pclk) begin
    if (|mif.we) begin
      mem[mif.addr] <= mif.new_word;
    end
  end

  a_write_stores_word: assert property (@(posedge pclk) disable iff (!presetn)
    (|mif.we) |=> mem[$past(mif.addr)] === $past(mif.new_word))
    else $error("written word not stored");

  a_idle_keeps_word: assert property (@(posedge pclk) disable iff (!presetn)
    (mif.we == '0) |=> mem[$past(mif.addr)] === $past(mif.old_word))
    else $error("array changed without write");

  a_lane_mask_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (|mif.we) |=> ((mem[$past(mif.addr)] ^ $past(mif.old_word)) & ~$past(lane_mask)) == '0)
    else $error("unselected lane changed");

endmodule : sbr_array

`default_nettype wire

// ==== sbr_mem_if.sv ====
`default_nettype none

interface sbr_mem_if;
  import sbr_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wword;
  logic [LANES-1:0]  we;
  logic [WORD_W-1:0] old_word;
  logic [WORD_W-1:0] new_word;

  modport ctrl (output addr, output wword, output we, input old_word, input new_word);
  modport mem  (input addr, input wword, input we, output old_word, output new_word);
endinterface : sbr_mem_if

`default_nettype wire

// ==== sbr_pkg.sv ====
`default_nettype none

package sbr_pkg;

  // Port geometry: 512 words of 32 data bits plus 4 parity bits
  localparam int ADDR_W      = 9;
  localparam int DEPTH       = 512;
  localparam int DATA_W      = 32;
  localparam int PAR_W       = 4;
  localparam int WORD_W      = 36;
  localparam int LANES       = 4;
  localparam int LANE_DATA_W = 8;

  // APB register map, byte addresses
  localparam int              PADDR_W       = 8;
  localparam logic [7:0]      OFS_CTRL      = 8'h00;
  localparam logic [7:0]      OFS_INIT_LO   = 8'h04;
  localparam logic [7:0]      OFS_INIT_HI   = 8'h08;
  localparam logic [7:0]      OFS_LATCH_LO  = 8'h0c;
  localparam logic [7:0]      OFS_LATCH_HI  = 8'h10;

  // Control register fields
  localparam int              CTRL_MODE_LSB = 0;
  localparam int              CTRL_MODE_W   = 2;
  localparam int              CTRL_OREG_BIT = 2;

  // Values after reset
  localparam logic [1:0]      MODE_RST      = 2'h0;
  localparam logic            OREG_RST      = 1'b0;
  localparam logic [35:0]     INIT_RST      = 36'h0_0000_0000;
  localparam logic [35:0]     LATCH_RST     = 36'h0_0000_0000;

  typedef enum logic [1:0] {
    WM_WRITE_FIRST = 2'b00,
    WM_READ_FIRST  = 2'b01,
    WM_NO_CHANGE   = 2'b10
  } sbr_wmode_type;

endpackage : sbr_pkg

`default_nettype wire

// ==== sbr_port.sv ====
// Contract
// - An enabled edge without write loads the addressed word into the output latch, array unchanged.
// - An enabled write in write-first mode stores the word and shows the new word on the output.
// - Set/reset on an enabled edge loads the configured init value into the output latch.
// - Set/reset leaves memory untouched and ignores address and data inputs.
// - With enable low no write, read or set/reset happens at that edge.
// - A disabled edge changes neither the array nor the output latch.
// - With the output register selected and output_reg_clock_enable high, data reaches the output one cycle later; with it low the output holds.
// - Enable and set/reset are active high, acting only when sampled high.
// - Parity bits are read, written and stored like any data bit.
// - Each of the four byte write enables steers its own byte lane.
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none

module sbr_port (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [sbr_pkg::PADDR_W-1:0]  paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         en,
  input  wire logic [sbr_pkg::LANES-1:0]    we,
  input  wire logic                         sync_output_set_reset,
  input  wire logic [sbr_pkg::ADDR_W-1:0]   addr,
  input  wire logic [sbr_pkg::DATA_W-1:0]   write_word_in,
  input  wire logic [sbr_pkg::PAR_W-1:0]    write_parity_in,
  input  wire logic                         output_reg_clock_enable,
  output logic      [sbr_pkg::DATA_W-1:0]   read_word_out,
  output logic      [sbr_pkg::PAR_W-1:0]    read_parity_out
);
  import sbr_pkg::*;

  sbr_mem_if mif ();

  logic [1:0]        ctrl_mode;
  logic              out_reg_sel;
  logic [WORD_W-1:0] init_word;
  logic [WORD_W-1:0] latch;
  logic [WORD_W-1:0] out_q;
  sbr_wmode_type     wmode;
  logic              do_init;
  logic              do_read;
  logic              do_write;
  logic              apb_setup;
  logic              apb_wr;
  logic [31:0]       next_prdata;
  logic              next_pslverr;

  sbr_array u_array (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (mif)
  );

  // Port operation decode; only high levels act
  assign do_init  = en && sync_output_set_reset;
  assign do_read  = en && !sync_output_set_reset && (we == '0);
  assign do_write = en && !sync_output_set_reset && (we != '0);

  assign mif.addr  = addr;
  assign mif.wword = {write_parity_in, write_word_in};
  assign mif.we    = (en && !sync_output_set_reset) ? we : '0;

  // Reserved mode code falls back to write-first
  always_comb begin
    unique case (ctrl_mode)
      2'b00:   wmode = WM_WRITE_FIRST;
      2'b01:   wmode = WM_READ_FIRST;
      2'b10:   wmode = WM_NO_CHANGE;
      default: wmode = WM_WRITE_FIRST;
    endcase
  end

  // Output latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= LATCH_RST;
    end else if (do_init) begin
      latch <= init_word;
    end else if (do_read) begin
      latch <= mif.old_word;
    end else if (do_write) begin
      unique case (wmode)
        WM_WRITE_FIRST: latch <= mif.new_word;
        WM_READ_FIRST:  latch <= mif.old_word;
        WM_NO_CHANGE:   latch <= latch;
      endcase
    end
  end

  // Optional output register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= LATCH_RST;
    end else if (output_reg_clock_enable) begin
      out_q <= latch;
    end
  end

  assign {read_parity_out, read_word_out} = out_reg_sel ? out_q : latch;

  // APB slave, no wait states
  assign pready    = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mode   <= MODE_RST;
      out_reg_sel <= OREG_RST;
    end else if (apb_wr && paddr == OFS_CTRL) begin
      ctrl_mode   <= pwdata[CTRL_MODE_LSB +: CTRL_MODE_W];
      out_reg_sel <= pwdata[CTRL_OREG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_word <= INIT_RST;
    end else if (apb_wr && paddr == OFS_INIT_LO) begin
      init_word[DATA_W-1:0] <= pwdata;
    end else if (apb_wr && paddr == OFS_INIT_HI) begin
      init_word[WORD_W-1:DATA_W] <= pwdata[PAR_W-1:0];
    end
  end

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      OFS_CTRL:     next_prdata = {29'h000_0000, out_reg_sel, ctrl_mode};
      OFS_INIT_LO:  next_prdata = init_word[DATA_W-1:0];
      OFS_INIT_HI:  next_prdata = {28'h000_0000, init_word[WORD_W-1:DATA_W]};
      OFS_LATCH_LO: next_prdata = latch[DATA_W-1:0];
      OFS_LATCH_HI: next_prdata = {28'h000_0000, latch[WORD_W-1:DATA_W]};
      default:      next_pslverr = 1'b1;
    endcase
  end

  // Answer captured in the setup cycle, valid through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  a_read_loads_latch: assert property (
    do_read |=> latch == $past(mif.old_word))
    else $error("read did not load addressed word");

  a_write_first_out: assert property (
    (do_write && wmode == WM_WRITE_FIRST) |=> latch == $past(mif.new_word))
    else $error("write-first output not new word");

  a_init_loads_latch: assert property (
    do_init |=> latch == $past(init_word))
    else $error("set/reset did not load init value");

  a_init_no_write: assert property (
    do_init |-> mif.we == '0)
    else $error("set/reset wrote the array");

  a_disabled_no_op: assert property (
    !en |-> mif.we == '0)
    else $error("write while disabled");

  a_disabled_holds_out: assert property (
    (!en && !(apb_wr && paddr == OFS_CTRL)) ##1 !out_reg_sel |->
      {read_parity_out, read_word_out} == $past(latch))
    else $error("output changed on disabled edge");

  a_out_reg_delay: assert property (
    (out_reg_sel && output_reg_clock_enable) ##1 out_reg_sel |->
      {read_parity_out, read_word_out} == $past(latch))
    else $error("output register latency wrong");

  a_read_first_old: assert property (
    (do_write && wmode == WM_READ_FIRST) |=> latch == $past(mif.old_word))
    else $error("read-first output not old word");

  a_no_change_hold: assert property (
    (do_write && wmode == WM_NO_CHANGE) |=> $stable(latch))
    else $error("no-change write altered output");

  a_apb_unmapped_err: assert property (
    (apb_setup && next_pslverr) |=> pslverr)
    else $error("unmapped address not flagged");

  a_disabled_keeps_latch: assert property (
    !en |=> $stable(latch))
    else $error("output latch changed on disabled edge");

  a_out_reg_hold: assert property (
    (out_reg_sel && !output_reg_clock_enable) ##1 out_reg_sel |->
      {read_parity_out, read_word_out} == $past({read_parity_out, read_word_out}))
    else $error("output register moved while not enabled");

  a_apb_write_zero: assert property (
    (apb_setup && pwrite) |=> prdata == 32'h0000_0000)
    else $error("write returned nonzero read data");

  c_read:      cover property (do_read ##1 do_read);
  c_write:     cover property (do_write ##1 do_read);
  c_init_load: cover property (do_write ##1 do_init ##1 !en);
  c_out_reg:   cover property (out_reg_sel && do_read ##1 output_reg_clock_enable);
  c_out_hold:  cover property (out_reg_sel && !output_reg_clock_enable);

endmodule : sbr_port

`default_nettype wire

// ==== sbr_user_model.sv ====
`default_nettype none

module sbr_user_model (
  input  wire logic                  pclk,
  input  wire logic                  oreg_sel,
  output logic                       en,
  output logic [sbr_pkg::LANES-1:0]  we,
  output logic                       init_load,
  output logic [sbr_pkg::ADDR_W-1:0] addr,
  output logic [sbr_pkg::WORD_W-1:0] word,
  output logic                       orce
);
  timeunit 1ns;
  timeprecision 1ns;
  import sbr_pkg::*;

  initial begin
    en        = 1'b0;
    we        = 4'h0;
    init_load = 1'b0;
    addr      = 9'h000;
    word      = 36'h0_0000_0000;
    orce      = 1'b1;
  end

  task drive(input logic e, input logic [3:0] w, input logic s, input logic [8:0] a,
             input logic [35:0] d, input logic r = 1'b1);
    @(posedge pclk);
    en        <= e;
    we        <= w;
    init_load <= s && !oreg_sel;
    addr      <= a;
    word      <= d;
    orce      <= r;
  endtask : drive

  // Disabled: address and data wander, never left at the last value
  task idle(input int n);
    repeat (n) begin
      @(posedge pclk);
      en   <= 1'b0;
      init_load <= 1'b0;
      we   <= 4'h0;
      addr <= ~addr;
      word <= ~word;
    end
  endtask : idle
endmodule : sbr_user_model

`default_nettype wire

// ==== sync_block_ram_port_tb_top.sv ====
`default_nettype none

`define CHK(nm, e, g) total_checks++; if ((e) !== (g)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, e, g); end

module sync_block_ram_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sbr_pkg::*;

  typedef struct {int due; logic apb; logic [35:0] exp;} sbr_note_type;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, oreg;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rword;
  logic        en, init_load, orce;
  logic [3:0]  we, rpar;
  logic [8:0]  addr;
  logic [35:0] uw;
  logic [32:0] apb_rd;
  sbr_note_type q[$];
  int          cyc, miscompares, total_checks, seed;

  sbr_port u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .en(en), .we(we), .sync_output_set_reset(init_load),
    .addr(addr), .write_word_in(uw[31:0]), .write_parity_in(uw[35:32]),
    .output_reg_clock_enable(orce), .read_word_out(rword), .read_parity_out(rpar));

  sbr_user_model u_user (.pclk(pclk), .oreg_sel(oreg), .en(en), .we(we), .init_load(init_load),
    .addr(addr), .word(uw), .orce(orce));

  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  // Oldest note is judged at the falling edge it falls due
  always @(negedge pclk) begin
    cyc++;
    if (q.size() > 0 && q[0].due <= cyc) begin
      if (q[0].apb) begin `CHK("apb", q[0].exp, {3'h0, apb_rd}) end
      else begin `CHK("port", q[0].exp, {rpar, rword}) end
      void'(q.pop_front());
    end
  end

  task test_done();
    if (q.size() > 0) miscompares++;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task note(input logic a, input int lat, input logic [35:0] e);
    q.push_back('{cyc + lat, a, e});
  endtask : note

  task op(input logic [3:0] w, input logic s, input logic [8:0] a, input logic [35:0] d,
          input logic [35:0] e);
    u_user.drive(1'b1, w, s, a, d);
    note(1'b0, 2, e);
  endtask : op

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [35:0] e);
    int n;
    u_user.idle(1);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
    apb_rd  <= {pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!w) note(1'b1, 1, e);
  endtask : apb

  function automatic logic [35:0] rnd();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[35:0];
  endfunction : rnd

  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] w);
    logic [35:0] r;
    r = o;
    for (int i = 0; i < 4; i++) if (w[i]) begin
      r[8*i +: 8] = n[8*i +: 8];
      r[32+i] = n[32+i];
    end
    return r;
  endfunction : merge

  initial begin
    #2000000;
    miscompares++;
    test_done();
  end

  initial begin
    logic [35:0] d0, d1, iv, mg;
    logic [8:0] a, b;
    seed    = 32'hfadc;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    oreg    = 1'b0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0, 36'h0);
    apb(1'b0, 8'h14, 32'h0, 36'h1_0000_0000);
    iv = rnd();
    apb(1'b1, OFS_INIT_LO, iv[31:0], 36'h0);
    apb(1'b1, OFS_INIT_HI, {28'h0, iv[35:32]}, 36'h0);
    apb(1'b0, OFS_INIT_HI, 32'h0, {32'h0, iv[35:32]});
    for (int m = 0; m < 4; m++) begin
      a  = 9'(m * 37 + 5);
      d0 = rnd();
      d1 = rnd();
      apb(1'b1, OFS_CTRL, 32'h0, 36'h0);
      op(4'hf, 1'b0, a, d0, d0);
      op(4'hf, 1'b1, a, rnd(), iv);
      apb(1'b1, OFS_CTRL, 32'(m), 36'h0);
      op(4'hf, 1'b0, a, d1, m == 1 ? d0 : m == 2 ? iv : d1);
      op(4'h0, 1'b0, a, rnd(), d1);
    end
    apb(1'b1, OFS_CTRL, 32'h0, 36'h0);
    mg = merge(d1, d0, 4'h5);
    op(4'h5, 1'b0, a, d0, mg);
    u_user.drive(1'b0, 4'hf, 1'b1, a, rnd());
    note(1'b0, 2, mg);
    op(4'h0, 1'b0, a, rnd(), mg);
    apb(1'b0, OFS_LATCH_LO, 32'h0, {4'h0, mg[31:0]});
    b  = a + 9'h1;
    d0 = rnd();
    op(4'hf, 1'b0, b, d0, d0);
    oreg <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h4, 36'h0);
    u_user.drive(1'b1, 4'h0, 1'b0, a, rnd());
    note(1'b0, 2, d0);
    note(1'b0, 3, mg);
    u_user.idle(1);
    u_user.drive(1'b1, 4'h0, 1'b0, b, rnd(), 1'b0);
    note(1'b0, 2, mg);
    u_user.drive(1'b0, 4'h0, 1'b0, a, rnd());
    note(1'b0, 2, d0);
    u_user.idle(4);
    test_done();
  end
endmodule : sync_block_ram_port_tb_top

`default_nettype wire
